// ==== verilog/ccf_top.sv ====
// cache data ram strobes, flush control, remap flush and board test logic
// ----------------------------------------
// Summary of operation
// RQ1 - two active-low chip enables pick the lower or upper 16KB of data ram
// RQ2 - with the 16KB size the upper-half chip enable never asserts
// RQ3 - low byte enable gates bits 0-7, high byte enable gates bits 8-15
// RQ4 - hits in set A use set A enables, hits in set B use set B's
// RQ5 - own address latch strobe for the ram latches, pipeline safe
// RQ6 - ram outputs drive the data bus only during a read hit
// RQ7 - flush clears every valid bit, data ram untouched, next access misses
// RQ8 - flush from pin low while enabled, software bit, or remap update
// RQ9 - flush runs about 12 double-rate clock cycles
// RQ10 - during flush cache acts disabled, misses; then re-enables itself
// RQ11 - disabled cache flushes at once, enabled waits for T2/T1/T1P end
// RQ12 - pin low by mid-T2 or mid-T1P flushes at that state end
// RQ13 - flush pin ignored while cache disabled
// RQ14 - flush pin accepted synchronous or asynchronous to the clock
// RQ15 - software flush works enabled or disabled, ignored during diagnostics
// RQ16 - software flush bit self-clears when the flush completes
// RQ17 - remap update with auto flush on sets the software flush bit
// RQ18 - any I/O read or write of port E9 is a remap update
// RQ19 - writes to EA, EB, or ED at two indexes, config writes enabled
// RQ20 - tristate input low floats every output
// RQ21 - loopback test maps inputs to outputs inverted, map by three pins
// RQ22 - map A ORs reset with bus master, map C ANDs hold ack and request
// RQ23 - tester enters or leaves loopback with tristate low and read/write pulse
// RQ24 - power-on reset forces loopback test mode off
// RQ25 - requests during a pending or running flush merge into it
// RQ26 - asynchronous flush pin is synchronised before use
// ----------------------------------------
`timescale 1ns/100ps
module ccf_top
   import ccf_pkg::*;
#(
   parameter int FLUSH_CYC = FLUSH_CLK2_CYC
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire ccf_bus_t          bus_state,
   input  wire logic              state_end,
   input  wire logic              cyc_active,
   input  wire logic              cyc_write,
   input  wire logic              cyc_hit,
   input  wire logic              hit_set_b,
   input  wire logic              addr_upper,
   input  wire logic              cpu_byte_lo_n,
   input  wire logic              cpu_byte_hi_n,
   input  wire logic              diag_busy,
   input  wire logic              io_cycle,
   input  wire logic              io_write,
   input  wire logic [7:0]        io_port,
   input  wire logic [7:0]        cfg_index,
   input  wire logic              cfg_wr_en,
   input  wire logic              flush_n,
   input  wire logic              tristate_n,
   input  wire logic              io_rd_n,
   input  wire logic              io_wr_n,
   input  wire logic              xd0,
   input  wire logic              power_on_reset_in,
   input  wire logic              processor_reset_in,
   input  wire logic              bus_master_n,
   input  wire logic              hold_ack,
   input  wire logic              hold_req,
   input  wire logic              uncached_cycle_n,
   input  wire logic              protected_cycle_n,
   input  wire logic [ICT_W-1:0]  map_a_pins,
   input  wire logic [ICT_W-1:0]  map_b_pins,
   input  wire logic [ICT_W-1:0]  map_c_pins,
   output logic                   lower_half_chip_en_n,
   output logic                   upper_half_chip_en_n,
   output logic                   low_byte_lane_en_n,
   output logic                   high_byte_lane_en_n,
   output logic                   set_a_output_en_n,
   output logic                   set_a_write_en_n,
   output logic                   set_b_output_en_n,
   output logic                   set_b_write_en_n,
   output logic                   sram_addr_latch_strobe,
   output logic                   cache_miss,
   output logic                   tag_valid_clear,
   output logic [ICT_W-1:0]       loopback_out,
   output logic                   outputs_oe_n
);
   localparam int IW = $clog2(ICT_PULSE_CYC + 1);

   typedef struct packed {
      logic [NPIN-1:0]   s1;
      logic [NPIN-1:0]   s2;
      logic              flush_d;
      logic              en;
      logic              flush_bit;
      logic              auto_en;
      logic              size32;
      logic              pin_loopback_test;
      logic [IW-1:0]     ict_cnt;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] wa;
      logic [31:0]       wd;
      logic              wlo;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [9:0]        strb;
   } ccf_top_state_t;

   ccf_top_state_t s;
   ccf_top_state_t next_s;
   ccf_flush_if    fl ();

   logic sw_set;
   logic hw_req;
   logic remap_evt;
   logic eff_en;
   logic rd_hit;
   logic wr_hit;
   logic access;
   logic tri_act;
   logic [2:0] map_sel;
   logic [ICT_W-1:0] map_a_eff;
   logic [ICT_W-1:0] map_c_eff;

   // ----------------------------------------
   // flush sequencer
   // ----------------------------------------
   ccf_flush_seq #(.FLUSH_CYC(FLUSH_CYC)) u_seq (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fl      (fl.seq)
   );

   assign fl.cache_en = s.en;
   assign fl.slot_ok  = state_end && (bus_state != BUS_IDLE); // RQ11 RQ12
   assign fl.req      = sw_set || hw_req; // RQ8
   // the pin level is only looked at after the second sync stage
   assign hw_req      = s.en && !s.s2[PIN_FLUSH] && s.flush_d; // RQ13 RQ14
   assign eff_en      = s.en && !fl.busy; // RQ10

   // ----------------------------------------
   // remap update detection
   // ----------------------------------------
   always_comb begin
      remap_evt = 1'b0;
      if (io_cycle) begin
         if (io_port == PORT_REMAP_SET) begin
            remap_evt = 1'b1; // RQ18
         end else if (io_write && cfg_wr_en) begin
            if (io_port == PORT_REMAP_LO || io_port == PORT_REMAP_HI) begin
               remap_evt = 1'b1; // RQ19
            end else if (io_port == PORT_CFG_DATA &&
                         (cfg_index == IDX_REMAP_ONE || cfg_index == IDX_REMAP_TWO)) begin
               remap_evt = 1'b1; // RQ19
            end
         end
      end
   end

   // ----------------------------------------
   // cache cycle decode
   // ----------------------------------------
   assign access = cyc_active && cyc_hit && eff_en;
   assign rd_hit = access && !cyc_write;
   assign wr_hit = access && cyc_write;
   assign tri_act = !s.s2[PIN_TRI];

   // ----------------------------------------
   // state update
   // ----------------------------------------
   always_comb begin
      next_s         = s;
      next_s.s1      = {power_on_reset_in, xd0, io_wr_n, io_rd_n, tristate_n, flush_n};
      next_s.s2      = s.s1; // RQ26
      next_s.flush_d = s.s2[PIN_FLUSH];
      sw_set         = 1'b0;

      // write channel: address and data in either order
      if (awvalid && awready) begin
         next_s.aw_got = 1'b1;
         next_s.wa     = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_got = 1'b1;
         next_s.wd    = wdata;
         next_s.wlo   = wstrb[0];
      end
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         if (s.wa == CTRL_OFS) begin
            if (s.wlo) begin
               next_s.en      = s.wd[CTL_EN];
               next_s.auto_en = s.wd[CTL_AUTO];
               next_s.size32  = s.wd[CTL_SIZE32];
               sw_set         = s.wd[CTL_FLUSH] && !diag_busy; // RQ15
            end
         end else if (s.wa != STAT_OFS) begin
            next_s.bresp = RESP_SLVERR;
         end
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end

      // read channel
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = 32'h0000_0000;
         if (araddr == CTRL_OFS) begin
            next_s.rdata[CTL_EN]     = s.en;
            next_s.rdata[CTL_FLUSH]  = s.flush_bit;
            next_s.rdata[CTL_AUTO]   = s.auto_en;
            next_s.rdata[CTL_SIZE32] = s.size32;
         end else if (araddr == STAT_OFS) begin
            next_s.rdata[ST_BUSY] = fl.busy;
            next_s.rdata[ST_PEND] = fl.pending;
            next_s.rdata[ST_EFF]  = eff_en;
            next_s.rdata[ST_ICT]  = s.pin_loopback_test;
         end else begin
            next_s.rresp = RESP_SLVERR;
         end
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // software flush bit: set wins over the completion clear
      if (remap_evt && s.auto_en && !diag_busy) begin
         sw_set = 1'b1; // RQ17
      end
      if (sw_set) begin
         next_s.flush_bit = 1'b1;
      end else if (fl.done) begin
         next_s.flush_bit = 1'b0; // RQ16
      end

      // loopback mode entry and exit
      if (s.s2[PIN_POR]) begin
         next_s.pin_loopback_test     = 1'b0; // RQ24
         next_s.ict_cnt = '0;
      end else if (tri_act && !s.s2[PIN_IORD] && !s.s2[PIN_IOWR]) begin
         if (s.ict_cnt == IW'(ICT_PULSE_CYC - 1)) begin
            next_s.pin_loopback_test = s.s2[PIN_XD0]; // RQ23
         end
         if (s.ict_cnt != IW'(ICT_PULSE_CYC)) begin
            next_s.ict_cnt = s.ict_cnt + 1'b1;
         end
      end else begin
         next_s.ict_cnt = '0;
      end

      // registered ram strobes, enables 0-7 inactive high, latch strobe and miss active high
      next_s.strb[0] = !(access && !(addr_upper && s.size32)); // RQ1
      next_s.strb[1] = !(access && addr_upper && s.size32); // RQ1 RQ2
      next_s.strb[2] = !(access && (!cyc_write || !cpu_byte_lo_n)); // RQ3
      next_s.strb[3] = !(access && (!cyc_write || !cpu_byte_hi_n)); // RQ3
      next_s.strb[4] = !(rd_hit && !hit_set_b); // RQ4 RQ6
      next_s.strb[5] = !(wr_hit && !hit_set_b); // RQ4
      next_s.strb[6] = !(rd_hit && hit_set_b); // RQ4 RQ6
      next_s.strb[7] = !(wr_hit && hit_set_b); // RQ4
      // latch the ram address at each new address phase, pipelined or not
      next_s.strb[8] = (bus_state == BUS_T1) || (bus_state == BUS_T1P); // RQ5
      next_s.strb[9] = cyc_active && !(cyc_hit && eff_en); // RQ10
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s         <= '0;
         s.s1      <= {NPIN{1'b1}} ^ {1'b1, {(NPIN-1){1'b0}}};
         s.s2      <= {NPIN{1'b1}} ^ {1'b1, {(NPIN-1){1'b0}}};
         s.flush_d <= 1'b1;
         s.strb    <= 10'h0ff;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // loopback test maps
   // ----------------------------------------
   assign map_sel   = {uncached_cycle_n, protected_cycle_n, flush_n};
   always_comb begin
      map_a_eff = map_a_pins;
      map_c_eff = map_c_pins;
      map_a_eff[ICT_RST_BIT]  = processor_reset_in || bus_master_n; // RQ22
      map_c_eff[ICT_HOLD_BIT] = hold_ack && hold_req; // RQ22
   end

   genvar gi;
   generate
      for (gi = 0; gi < ICT_W; gi++) begin : g_map
         always_comb begin
            loopback_out[gi] = 1'b0;
            if (s.pin_loopback_test) begin
               unique case (map_sel)
                  MAP_A:   loopback_out[gi] = !map_a_eff[gi]; // RQ21
                  MAP_B:   loopback_out[gi] = !map_b_pins[gi]; // RQ21
                  MAP_C:   loopback_out[gi] = !map_c_eff[gi]; // RQ21
                  default: loopback_out[gi] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign awready = !s.aw_got && !s.bvalid;
   assign wready  = !s.w_got && !s.bvalid;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign arready = !s.rvalid;
   assign rvalid  = s.rvalid;
   assign rdata   = s.rdata;
   assign rresp   = s.rresp;

   // loopback mode holds the ram strobes idle
   assign lower_half_chip_en_n   = s.strb[0] || s.pin_loopback_test;
   assign upper_half_chip_en_n   = s.strb[1] || s.pin_loopback_test;
   assign low_byte_lane_en_n     = s.strb[2] || s.pin_loopback_test;
   assign high_byte_lane_en_n    = s.strb[3] || s.pin_loopback_test;
   assign set_a_output_en_n      = s.strb[4] || s.pin_loopback_test;
   assign set_a_write_en_n       = s.strb[5] || s.pin_loopback_test;
   assign set_b_output_en_n      = s.strb[6] || s.pin_loopback_test;
   assign set_b_write_en_n       = s.strb[7] || s.pin_loopback_test;
   assign sram_addr_latch_strobe = s.strb[8] && !s.pin_loopback_test;
   assign cache_miss             = s.strb[9];
   assign tag_valid_clear        = fl.busy; // RQ7
   assign outputs_oe_n           = tri_act; // RQ20

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_upper_unused: assert property (!$past(s.size32) |-> upper_half_chip_en_n) // RQ2
      else $error("upper chip enable used in small cache");
   a_oe_read_hit: assert property (!set_a_output_en_n || !set_b_output_en_n // RQ6
      |-> $past(cyc_active && cyc_hit && !cyc_write && eff_en))
      else $error("ram output enabled without read hit");
   a_miss_flush: assert property ($past(fl.busy && cyc_active) |-> cache_miss) // RQ10
      else $error("no miss during flush");
   a_sw_clear: assert property (fl.done && !sw_set |=> !s.flush_bit) // RQ16
      else $error("flush bit not cleared at completion");
   a_remap_set: assert property (remap_evt && s.auto_en && !diag_busy // RQ17
      |=> s.flush_bit ##[1:3] (fl.busy || fl.pending))
      else $error("remap update did not start flush");
   a_pin_ignored: assert property (!s.en && !sw_set |-> !fl.req) // RQ13
      else $error("flush pin used while disabled");
   a_tri_float: assert property ($fell(s.s2[PIN_TRI]) |-> outputs_oe_n) // RQ20
      else $error("outputs driven in tristate test");
   a_ict_reset: assert property (s.s2[PIN_POR] |=> !s.pin_loopback_test) // RQ24
      else $error("loopback mode survived power-on reset");
   a_ict_invert: assert property (s.pin_loopback_test && map_sel == MAP_B // RQ21
      |-> loopback_out == ~map_b_pins)
      else $error("loopback map b not inverted");
endmodule

// ==== verilog/ccf_pkg.sv ====
// constants and types shared by the cache flush and data ram control files
package ccf_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int         ADDR_W      = 4;
   localparam logic [3:0] CTRL_OFS    = 4'h0;
   localparam logic [3:0] STAT_OFS    = 4'h4;
   localparam int         CTL_EN      = 0;
   localparam int         CTL_FLUSH   = 1;
   localparam int         CTL_AUTO    = 2;
   localparam int         CTL_SIZE32  = 3;
   localparam int         ST_BUSY     = 0;
   localparam int         ST_PEND     = 1;
   localparam int         ST_EFF      = 2;
   localparam int         ST_ICT      = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS  = 20;
   localparam int ICT_PULSE_NS   = 100;
   localparam int ICT_PULSE_CYC  = (ICT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLUSH_CLK2_CYC = 12;

   // ----------------------------------------
   // remap update decode
   // ----------------------------------------
   localparam logic [7:0] PORT_REMAP_SET = 8'he9;
   localparam logic [7:0] PORT_REMAP_LO  = 8'hea;
   localparam logic [7:0] PORT_REMAP_HI  = 8'heb;
   localparam logic [7:0] PORT_CFG_DATA  = 8'hed;
   localparam logic [7:0] IDX_REMAP_ONE  = 8'h0b;
   localparam logic [7:0] IDX_REMAP_TWO  = 8'h0c;

   // ----------------------------------------
   // synchronised pins and loopback maps
   // ----------------------------------------
   localparam int         NPIN      = 6;
   localparam int         PIN_FLUSH = 0;
   localparam int         PIN_TRI   = 1;
   localparam int         PIN_IORD  = 2;
   localparam int         PIN_IOWR  = 3;
   localparam int         PIN_XD0   = 4;
   localparam int         PIN_POR   = 5;
   localparam logic [2:0] MAP_A     = 3'h4;
   localparam logic [2:0] MAP_B     = 3'h2;
   localparam logic [2:0] MAP_C     = 3'h1;
   localparam int         ICT_W     = 15;
   localparam int         ICT_RST_BIT  = 10;
   localparam int         ICT_HOLD_BIT = 0;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_T1   = 2'b01,
      BUS_T2   = 2'b10,
      BUS_T1P  = 2'b11
   } ccf_bus_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_PEND = 2'b01,
      SEQ_RUN  = 2'b10
   } ccf_seq_t;
endpackage

// ==== verilog/ccf_flush_if.sv ====
// flush request and status carrier between control and sequencer
`timescale 1ns/100ps
interface ccf_flush_if;
   logic req;
   logic cache_en;
   logic slot_ok;
   logic busy;
   logic pending;
   logic done;
   modport seq (input req, input cache_en, input slot_ok,
                output busy, output pending, output done);
   modport ctl (output req, output cache_en, output slot_ok,
                input busy, input pending, input done);
endinterface

// ==== verilog/ccf_flush_seq.sv ====
// flush sequencer: pends, runs the valid-bit clear, signals completion
`timescale 1ns/100ps
module ccf_flush_seq
   import ccf_pkg::*;
#(
   parameter int FLUSH_CYC = FLUSH_CLK2_CYC
)(
   input wire logic aclk,
   input wire logic aresetn,
   ccf_flush_if.seq fl
);
   localparam int CW = $clog2(FLUSH_CYC + 1);

   typedef struct packed {
      ccf_seq_t        st;
      logic [CW-1:0]   cnt;
      logic            done;
   } ccf_seq_state_t;

   ccf_seq_state_t s;
   ccf_seq_state_t next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      unique case (s.st)
         SEQ_IDLE: begin
            if (fl.req) begin
               // disabled cache starts at once, enabled waits for a state end
               if (!fl.cache_en || fl.slot_ok) begin // RQ11
                  next_s.st  = SEQ_RUN;
                  next_s.cnt = CW'(FLUSH_CYC - 1); // RQ9
               end else begin
                  next_s.st = SEQ_PEND;
               end
            end
         end
         SEQ_PEND: begin
            if (!fl.cache_en || fl.slot_ok) begin // RQ11 RQ12
               next_s.st  = SEQ_RUN;
               next_s.cnt = CW'(FLUSH_CYC - 1);
            end
         end
         SEQ_RUN: begin
            // further requests here fold into this flush
            if (s.cnt == '0) begin // RQ25
               next_s.st   = SEQ_IDLE;
               next_s.done = 1'b1;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         default: next_s.st = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '{st: SEQ_IDLE, cnt: '0, done: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign fl.busy    = (s.st == SEQ_RUN);
   assign fl.pending = (s.st == SEQ_PEND);
   assign fl.done    = s.done;

   a_flush_length: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
      $rose(fl.busy) |-> ##11 fl.busy ##1 (!fl.busy && fl.done))
      else $error("flush did not run twelve cycles");
   a_pend_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
      (s.st == SEQ_PEND && fl.cache_en && !fl.slot_ok) |=> !fl.busy)
      else $error("flush started inside a lookup");
   a_disabled_now: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
      (s.st == SEQ_IDLE && fl.req && !fl.cache_en) |=> fl.busy)
      else $error("flush on disabled cache did not start at once");
endmodule

// ==== sim/ccf_bus_model.sv ====
// processor bus model stepping through non-pipelined bus states
`timescale 1ns/100ps
module ccf_bus_model
   import ccf_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   output ccf_bus_t  bus_state,
   output logic      state_end
);
   // one clock per state: T1, T2, idle, so every state ends each cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) bus_state <= BUS_IDLE;
      else if (bus_state == BUS_IDLE) bus_state <= BUS_T1;
      else if (bus_state == BUS_T1) bus_state <= BUS_T2;
      else bus_state <= BUS_IDLE;
   end
   assign state_end = 1'b1;
endmodule

// ==== sim/test_ccf_top.sv ====
// self-checking bench for the cache flush and data ram control block
`timescale 1ns/100ps
module test_ccf_top
   import ccf_pkg::*;
;
   localparam int FC = 12;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rv;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp, rr;
   ccf_bus_t bus_state;
   logic state_end, cyc_active = 0, cyc_write = 0, cyc_hit = 0;
   logic hit_set_b = 0, addr_upper = 0, cpu_byte_lo_n = 1, cpu_byte_hi_n = 1;
   logic diag_busy = 0, io_cycle = 0, io_write = 0, cfg_wr_en = 0;
   logic [7:0] io_port = 0, cfg_index = 0;
   logic flush_n = 1, tristate_n = 1, io_rd_n = 1, io_wr_n = 1, xd0 = 0;
   logic power_on_reset_in = 0, processor_reset_in = 0, bus_master_n = 0;
   logic hold_ack = 0, hold_req = 0, uncached_cycle_n = 1, protected_cycle_n = 1;
   logic [ICT_W-1:0] map_a_pins = 0, map_b_pins = 0, map_c_pins = 0, loopback_out;
   logic lower_half_chip_en_n, upper_half_chip_en_n, low_byte_lane_en_n;
   logic high_byte_lane_en_n, set_a_output_en_n, set_a_write_en_n;
   logic set_b_output_en_n, set_b_write_en_n, sram_addr_latch_strobe;
   logic cache_miss, tag_valid_clear, outputs_oe_n;
   int n_mismatch = 0, tests_run = 0, ncyc = 0, nfl = 0;
   int seed = 32'h1675cfec;
   int ct[8] = '{1, 0, 4, 4, 4, 4, 0, 4};
   int ex[8] = '{FC, 0, FC, FC, FC, FC, 0, FC};
   logic [7:0] pt[8] = '{8'h00, 8'h00, 8'he9, 8'he9, 8'hea, 8'heb, 8'he9, 8'hed};

   ccf_bus_model i_bus (.aclk(aclk), .aresetn(aresetn), .bus_state(bus_state),
                        .state_end(state_end));
   ccf_top #(.FLUSH_CYC(FC)) i_dut (.*);

   initial forever #10 aclk = ~aclk;
   always @(negedge aclk) if (tag_valid_clear === 1'b1) nfl++;
   always @(posedge aclk) begin
      ncyc++;
      if (ncyc == 6000) begin
         n_mismatch++;
         test_done;
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         rr = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
      end while (!tb);
      bready <= 0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      logic ta, tv;
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(negedge aclk);
         ta = arvalid & arready;
         tv = rvalid;
         rv = rdata;
         rr = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 0;
      end while (!tv);
      rready <= 0;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      int n0;
      logic [7:0] es;
      logic [ICT_W-1:0] e15;
      repeat (11) @(posedge aclk);
      @(negedge aclk);
      chk({lower_half_chip_en_n, upper_half_chip_en_n, low_byte_lane_en_n,
           high_byte_lane_en_n, set_a_output_en_n, set_a_write_en_n, set_b_output_en_n,
           set_b_write_en_n, cache_miss, tag_valid_clear, outputs_oe_n}, 32'h7f8);
      @(posedge aclk);
      aresetn <= 1;
      {hold_ack, hold_req, map_b_pins, map_c_pins} <= $random(seed);
      {bus_master_n, processor_reset_in, map_a_pins} <= 17'($random(seed));
      cyc(4);
      wr(4'hc, 32'h1);
      chk(rr, RESP_SLVERR);
      rd(4'h8);
      chk(rr, RESP_SLVERR);
      chk(rv, 0);
      // hit strobes for read/write, set A/B, both cache sizes
      for (int i = 0; i < 8; i++) begin
         wr(CTRL_OFS, 32'(1 | (i[2] << 3)));
         cyc_write <= i[0];
         hit_set_b <= i[1];
         {addr_upper, cpu_byte_lo_n, cpu_byte_hi_n} <= 3'($random(seed));
         cyc_active <= 1;
         cyc_hit <= 1;
         cyc(3);
         @(negedge aclk);
         es = {addr_upper && i[2], !(addr_upper && i[2]), i[0] && cpu_byte_lo_n,
               i[0] && cpu_byte_hi_n, !(!i[0] && !i[1]), !(i[0] && !i[1]),
               !(!i[0] && i[1]), !(i[0] && i[1])};
         chk({lower_half_chip_en_n, upper_half_chip_en_n, low_byte_lane_en_n,
              high_byte_lane_en_n, set_a_output_en_n, set_a_write_en_n,
              set_b_output_en_n, set_b_write_en_n}, es);
         chk(cache_miss, 0);
         chk(sram_addr_latch_strobe, bus_state == BUS_T2);
         @(posedge aclk);
      end
      cyc_active <= 0;
      diag_busy <= 1;
      wr(CTRL_OFS, 32'h2);
      diag_busy <= 0;
      rd(CTRL_OFS);
      chk(rv[CTL_FLUSH], 0);
      wr(CTRL_OFS, 32'h2);
      rd(CTRL_OFS);
      chk(rv[CTL_FLUSH], 1);
      cyc(30);
      rd(CTRL_OFS);
      chk(rv, 0);
      // pin flush enabled and disabled, then remap update events
      for (int k = 0; k < 8; k++) begin
         n0 = nfl;
         wr(CTRL_OFS, 32'(ct[k]));
         if (k < 2) flush_n <= 0;
         else begin
            io_cycle <= 1;
            io_port <= pt[k];
            io_write <= (k > 2);
            cfg_wr_en <= 1;
            cfg_index <= IDX_REMAP_ONE;
         end
         @(posedge aclk);
         io_cycle <= 0;
         cyc(6);
         flush_n <= 1;
         cyc(30);
         chk(nfl - n0, ex[k]);
         rd(STAT_OFS);
         chk(rv[3:0], {1'b0, ct[k][0], 2'b00});
      end
      tristate_n <= 0;
      cyc(4);
      @(negedge aclk);
      chk(outputs_oe_n, 1);
      @(posedge aclk);
      xd0 <= 1;
      io_rd_n <= 0;
      io_wr_n <= 0;
      cyc(7);
      io_rd_n <= 1;
      io_wr_n <= 1;
      tristate_n <= 1;
      {uncached_cycle_n, protected_cycle_n, flush_n} <= 3'h4;
      cyc(6);
      rd(STAT_OFS);
      chk(rv[ST_ICT], 1);
      @(negedge aclk);
      e15 = ~map_a_pins;
      e15[ICT_RST_BIT] = ~(processor_reset_in | bus_master_n);
      chk(loopback_out, e15);
      @(posedge aclk);
      {uncached_cycle_n, protected_cycle_n, flush_n} <= 3'h2;
      @(negedge aclk);
      e15 = ~map_b_pins;
      chk(loopback_out, e15);
      @(posedge aclk);
      {uncached_cycle_n, protected_cycle_n, flush_n} <= 3'h1;
      @(negedge aclk);
      e15 = ~map_c_pins;
      e15[ICT_HOLD_BIT] = ~(hold_ack & hold_req);
      chk(loopback_out, e15);
      @(posedge aclk);
      power_on_reset_in <= 1;
      cyc(4);
      power_on_reset_in <= 0;
      cyc(4);
      rd(STAT_OFS);
      chk(rv[ST_ICT], 0);
      test_done;
   end
endmodule
